// [shared/usart_pkg.sv]
/*
 usart_pkg: register map, field layouts, reset values and types of the
 serial transceiver core.
 assumes: shared by baud_gen and usart_core; word-aligned APB byte addresses.
*/
package usart_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_DATA    = 8'h00;
	localparam logic [7:0] ADDR_CTRL_A  = 8'h04;
	localparam logic [7:0] ADDR_CTRL_B  = 8'h08;
	localparam logic [7:0] ADDR_CTRL_C  = 8'h0C;
	localparam logic [7:0] ADDR_BAUD_LO = 8'h10;
	localparam logic [7:0] ADDR_BAUD_HI = 8'h14;
	localparam logic [7:0] ADDR_PIN_DIR = 8'h18;

	// control_status_a bit positions, and B_NINTH in ctrl_b_type
	localparam int A_RX_DONE  = 7;
	localparam int A_TX_DONE  = 6;
	localparam int A_TX_EMPTY = 5;
	localparam int A_FRAME    = 4;
	localparam int A_OVERRUN  = 3;
	localparam int A_PARITY   = 2;
	localparam int A_DOUBLE   = 1;
	localparam int B_NINTH    = 1;

	// baud divisor and receiver phase counts
	localparam int         BAUD_WIDTH        = 12;
	localparam logic [3:0] LAST_PHASE_NORMAL = 4'hF;
	localparam logic [3:0] LAST_PHASE_DOUBLE = 4'h7;
	localparam logic [3:0] CHAR_BITS_BASE    = 4'h5;
	localparam logic [3:0] CHAR_BITS_MAX     = 4'h9;
	localparam int         FIFO_DEPTH        = 2;

	typedef struct packed {
		logic       rxIrqEn;
		logic       txDoneIrqEn;
		logic       txEmptyIrqEn;
		logic       rxEnable;
		logic       txEnable;
		logic       charSizeHigh;
		logic       spare;
		logic       txNinth;
	} ctrl_b_type;

	typedef struct packed {
		logic       spare;
		logic       syncSelect;
		logic [1:0] parityMode;
		logic       twoStop;
		logic [1:0] charSizeLow;
		logic       polarity;
	} ctrl_c_type;

	typedef struct packed {
		logic [8:0] data;
		logic       frameError;
		logic       overrun;
		logic       parityError;
	} rx_entry_type;

	typedef enum {RX_IDLE, RX_START, RX_BITS} rx_state_type;

	localparam ctrl_b_type CTRL_B_RESET = 8'h00;
	localparam ctrl_c_type CTRL_C_RESET = 8'h06;

endpackage : usart_pkg

// [rtl/baud_gen.sv]
/*
 baud_gen: reloadable 12-bit down-counter that makes the baud tick.
 assumes: divisor is register content; reload is a one-cycle pulse.
*/
module baud_gen
	import usart_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	// divisor control
	input  wire logic [BAUD_WIDTH-1:0] divisor,
	input  wire logic                  reload,
	// tick out
	output logic                       baudTick
);
	logic [BAUD_WIDTH-1:0] count;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			count <= '0;
		else if (reload || count == '0)
			count <= divisor;
		else
			count <= count - 1'b1;
	end

	// one tick per divisor+1 cycles
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			baudTick <= 1'b0;
		else
			baudTick <= (count == '0);
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_zero_ticks;
		count == '0 |=> baudTick;
	endproperty
	a_zero_ticks: assert property (p_zero_ticks)
		else $error("no baud tick after zero");

	property p_low_reload;
		reload |=> count == $past(divisor);
	endproperty
	a_low_reload: assert property (p_low_reload)
		else $error("counter not reloaded");

	property p_count_down;
		!reload && count != '0 |=> count == $past(count) - 12'h001;
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("counter restarted without reload");

endmodule : baud_gen

// [rtl/xck_sync.sv]
/*
 xck_sync: synchroniser and edge detector for the external transfer clock.
 assumes: external clock below a quarter of sys_clk.
*/
module xck_sync
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// external clock
	input  wire logic xckIn,
	// edge pulses
	output logic      rise,
	output logic      fall
);
	logic [2:0] stage;

	// stage[0] is only read by stage[1]
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			stage <= 3'h0;
		else
			stage <= {stage[1:0], xckIn};
	end

	assign rise = stage[1] && !stage[2];
	assign fall = !stage[1] && stage[2];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_rise_delay;
		$rose(xckIn) ##1 xckIn |-> ##1 rise;
	endproperty
	a_rise_delay: assert property (p_rise_delay)
		else $error("rise not two cycles late");

endmodule : xck_sync

// [rtl/usart_core.sv]
/*
 usart_core: baud generator, transmitter with one write buffer, receiver
 with two-entry fifo plus shift-register hold, behind an APB slave.
 assumes: rxd and xckIn synchronous to sys_clk; zero-wait APB master.
*/
// Design decisions made here: register access over APB and the placing of the registers.
// What this block does
// - baud counter reloads at zero and on every divisor low-byte write
// - baud tick each zero, rate is clock over divisor plus one
// - transmit bit every 16, 8 or 2 ticks by mode
// - receiver phase counter of 16 states, or 8 with double speed in asynchronous mode
// - divisor is twelve bits from a high and a low half
// - sync select zero means asynchronous, one synchronous
// - synchronous: pin direction out drives clock, in uses external clock
// - transfer clock pin only driven in synchronous mode
// - double speed halves divider and receiver samples to eight
// - two-entry receive fifo, each data read of a non-empty fifo pops one entry
// - error flags and ninth bit stored per entry, read before pop
// - with fifo full the finished character waits until next start
// - single transmit buffer gives back-to-back frames without gap
// - receiver uses transmitter format, flags frame, overrun, parity
// - five to nine data bits, one or two stops, odd/even parity
// - three interrupt requests: transmit done, buffer empty, receive done
// - receiver majority filter and false start rejection
// - external clock synchronised and edge detected, two cycles late
// - polarity zero: change on rising, sample on falling; one swaps
module usart_core
	import usart_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// serial line
	input  wire logic        rxd,
	output logic             txd,
	input  wire logic        xckIn,
	output logic             xckOut,
	output logic             xckOe,
	// interrupt requests
	output logic             rxDoneIrq,
	output logic             txDoneIrq,
	output logic             txEmptyIrq
);
	logic [7:0]   baudLow;
	logic [3:0]   baudHigh;
	logic [11:0]  divisorNow;
	ctrl_b_type   ctrlB;
	ctrl_c_type   ctrlC;
	logic         doubleSpeed;
	logic         pinDir;
	logic         txDone;
	logic         access;
	logic         wr;
	logic         mapped;
	logic [31:0]  readValue;
	logic         baudTick;
	logic         syncMode;
	logic         master;
	logic [3:0]   lastPhase;
	logic [3:0]   midPhase;
	logic         xckLevel;
	logic         extRise;
	logic         extFall;
	logic         xRise;
	logic         xFall;
	logic         changeEdge;
	logic         sampleEdge;
	logic [3:0]   charBits;
	logic         parityOn;
	logic         parityOdd;
	logic [8:0]   txBuf;
	logic         txBufFull;
	logic [12:0]  txShift;
	logic [12:0]  txFrame;
	logic [3:0]   txIdx;
	logic [3:0]   txLast;
	logic [3:0]   txPre;
	logic         txBusy;
	logic         txBitEn;
	logic         txLoad;
	logic         txParity;
	logic [2:0]   rxHist;
	logic         filt;
	logic         bitIn;
	rx_state_type rxState;
	logic [3:0]   rxPhase;
	logic [3:0]   rxCount;
	logic [3:0]   rxLast;
	logic [10:0]  rxBits;
	logic         rxSample;
	logic         startSeen;
	logic         frameEnd;
	rx_entry_type newEntry;
	rx_entry_type heldEntry;
	logic         heldValid;
	logic         pendingOverrun;
	rx_entry_type fifoMem [FIFO_DEPTH];
	logic         wrPtr;
	logic         rdPtr;
	logic [1:0]   fifoCount;
	logic         notEmpty;
	logic         room;
	logic         push;
	logic         pop;
	rx_entry_type head;

	function automatic logic [8:0] dataMask(input logic [3:0] bits);
		logic [8:0] m;
		m = '0;
		for (int i = 0; i < 9; i++)
			m[i] = (i < int'(bits));
		return m;
	endfunction : dataMask

	// apb: zero wait states, read data latched in the setup cycle
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign pready = penable;
	assign mapped = paddr == ADDR_DATA || paddr == ADDR_CTRL_A ||
		paddr == ADDR_CTRL_B || paddr == ADDR_CTRL_C ||
		paddr == ADDR_BAUD_LO || paddr == ADDR_BAUD_HI ||
		paddr == ADDR_PIN_DIR;
	assign pslverr = access && !mapped;
	assign pop = access && !pwrite && paddr == ADDR_DATA && notEmpty;

	always_comb
	begin
		readValue = '0;
		if (paddr == ADDR_DATA)
			readValue[7:0] = head.data[7:0];
		else if (paddr == ADDR_CTRL_A)
		begin
			readValue[A_RX_DONE] = notEmpty;
			readValue[A_TX_DONE] = txDone;
			readValue[A_TX_EMPTY] = !txBufFull;
			readValue[A_FRAME] = notEmpty && head.frameError;
			readValue[A_OVERRUN] = notEmpty && head.overrun;
			readValue[A_PARITY] = notEmpty && head.parityError;
			readValue[A_DOUBLE] = doubleSpeed;
		end
		else if (paddr == ADDR_CTRL_B)
		begin
			readValue[7:0] = ctrlB;
			readValue[B_NINTH] = notEmpty && head.data[8];
		end
		else if (paddr == ADDR_CTRL_C)
			readValue[7:0] = ctrlC;
		else if (paddr == ADDR_BAUD_LO)
			readValue[7:0] = baudLow;
		else if (paddr == ADDR_BAUD_HI)
			readValue[3:0] = baudHigh;
		else if (paddr == ADDR_PIN_DIR)
			readValue[0] = pinDir;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= readValue;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			baudLow <= 8'h00;
			baudHigh <= 4'h0;
			ctrlB <= CTRL_B_RESET;
			ctrlC <= CTRL_C_RESET;
			doubleSpeed <= 1'b0;
			pinDir <= 1'b0;
		end
		else if (wr && paddr == ADDR_BAUD_LO)
			baudLow <= pwdata[7:0];
		else if (wr && paddr == ADDR_BAUD_HI)
			baudHigh <= pwdata[3:0];
		else if (wr && paddr == ADDR_CTRL_A)
			doubleSpeed <= pwdata[A_DOUBLE];
		else if (wr && paddr == ADDR_CTRL_B)
			ctrlB <= ctrl_b_type'(pwdata[7:0]);
		else if (wr && paddr == ADDR_CTRL_C)
			ctrlC <= ctrl_c_type'(pwdata[7:0]);
		else if (wr && paddr == ADDR_PIN_DIR)
			pinDir <= pwdata[0];
	end

	// a low-byte write reloads the value being written, not the stale one
	assign divisorNow = (wr && paddr == ADDR_BAUD_LO) ?
		{baudHigh, pwdata[7:0]} : {baudHigh, baudLow};

	baud_gen u_baud (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.divisor  (divisorNow),
		.reload   (wr && paddr == ADDR_BAUD_LO),
		.baudTick (baudTick)
	);

	// clock mode; double speed is ignored when synchronous
	assign syncMode = ctrlC.syncSelect;
	assign master = syncMode && pinDir;
	assign xckOe = master;
	assign xckOut = xckLevel;
	assign lastPhase = (doubleSpeed && !syncMode) ?
		LAST_PHASE_DOUBLE : LAST_PHASE_NORMAL;
	assign midPhase = (lastPhase >> 1) + 4'h1;

	// master clock toggles every tick, so one bit takes two ticks
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			xckLevel <= 1'b0;
		else if (!master)
			xckLevel <= ctrlC.polarity;
		else if (baudTick)
			xckLevel <= !xckLevel;
	end

	xck_sync u_xck (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.xckIn   (xckIn),
		.rise    (extRise),
		.fall    (extFall)
	);

	assign xRise = syncMode && (pinDir ? baudTick && !xckLevel : extRise);
	assign xFall = syncMode && (pinDir ? baudTick && xckLevel : extFall);
	assign changeEdge = ctrlC.polarity ? xFall : xRise;
	assign sampleEdge = ctrlC.polarity ? xRise : xFall;

	// frame format shared by both directions
	assign charBits = ctrlB.charSizeHigh ? CHAR_BITS_MAX :
		CHAR_BITS_BASE + {2'h0, ctrlC.charSizeLow};
	assign parityOn = ctrlC.parityMode[1];
	assign parityOdd = ctrlC.parityMode[0];

	// transmitter
	assign txParity = ^(txBuf & dataMask(charBits)) ^ parityOdd;
	// index of the last stop bit: start, data, parity, stops
	assign txLast = charBits + {3'h0, parityOn} + {3'h0, ctrlC.twoStop} +
		4'h1;
	assign txBitEn = syncMode ? changeEdge :
		baudTick && txPre == lastPhase;
	assign txLoad = txBitEn && txBufFull && (!txBusy || txIdx == txLast);
	assign txd = txShift[0];

	always_comb
	begin
		txFrame = '1;
		txFrame[0] = 1'b0;
		for (int i = 0; i < 9; i++)
			if (i < int'(charBits))
				txFrame[i + 1] = txBuf[i];
		if (parityOn)
			txFrame[charBits + 4'h1] = txParity;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			txPre <= 4'h0;
		else if (!ctrlB.txEnable || syncMode)
			txPre <= 4'h0;
		else if (baudTick)
			txPre <= (txPre == lastPhase) ? 4'h0 : txPre + 4'h1;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			txShift <= '1;
			txIdx <= 4'h0;
			txBusy <= 1'b0;
		end
		else if (!ctrlB.txEnable)
		begin
			txShift <= '1;
			txBusy <= 1'b0;
		end
		else if (txLoad)
		begin
			txShift <= txFrame;
			txIdx <= 4'h0;
			txBusy <= 1'b1;
		end
		else if (txBitEn && txBusy && txIdx == txLast)
		begin
			txShift <= '1;
			txBusy <= 1'b0;
		end
		else if (txBitEn && txBusy)
		begin
			txShift <= {1'b1, txShift[12:1]};
			txIdx <= txIdx + 4'h1;
		end
	end

	// a write while the buffer is full is dropped
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			txBuf <= 9'h000;
			txBufFull <= 1'b0;
		end
		else if (wr && paddr == ADDR_DATA && !txBufFull)
		begin
			txBuf <= {ctrlB.txNinth, pwdata[7:0]};
			txBufFull <= 1'b1;
		end
		else if (txLoad)
			txBufFull <= 1'b0;
	end

	// set wins over the software clear
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			txDone <= 1'b0;
		else if (txBitEn && txBusy && txIdx == txLast && !txBufFull)
			txDone <= 1'b1;
		else if (wr && paddr == ADDR_CTRL_A && pwdata[A_TX_DONE])
			txDone <= 1'b0;
	end

	assign txDoneIrq = ctrlB.txDoneIrqEn && txDone;
	assign txEmptyIrq = ctrlB.txEmptyIrqEn && !txBufFull;
	assign rxDoneIrq = ctrlB.rxIrqEn && notEmpty;

	// receiver: three-tap majority filter on baud ticks
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rxHist <= 3'h7;
		else if (baudTick)
			rxHist <= {rxHist[1:0], rxd};
	end

	assign filt = (rxHist[0] && rxHist[1]) || (rxHist[0] && rxHist[2]) ||
		(rxHist[1] && rxHist[2]);
	assign bitIn = syncMode ? rxd : filt;
	assign rxSample = syncMode ? sampleEdge :
		baudTick && rxPhase == midPhase;
	assign startSeen = ctrlB.rxEnable && rxState == RX_IDLE &&
		(syncMode ? sampleEdge && !rxd : baudTick && !filt);
	assign rxLast = charBits + {3'h0, parityOn};
	assign frameEnd = rxState == RX_BITS && rxSample && rxCount == rxLast;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rxPhase <= 4'h0;
		else if (startSeen)
			rxPhase <= 4'h1;
		else if (baudTick && rxState != RX_IDLE)
			rxPhase <= (rxPhase == lastPhase) ? 4'h0 : rxPhase + 4'h1;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxState <= RX_IDLE;
			rxCount <= 4'h0;
			rxBits <= '0;
		end
		else if (!ctrlB.rxEnable)
			rxState <= RX_IDLE;
		else
			case (rxState)
				RX_IDLE:
					if (startSeen)
					begin
						rxState <= syncMode ? RX_BITS : RX_START;
						rxCount <= 4'h0;
					end
				RX_START:
					if (rxSample)
						rxState <= filt ? RX_IDLE : RX_BITS;
				RX_BITS:
					if (rxSample)
					begin
						rxBits[rxCount] <= bitIn;
						rxCount <= rxCount + 4'h1;
						if (rxCount == rxLast)
							rxState <= RX_IDLE;
					end
				default:
					rxState <= RX_IDLE;
			endcase
	end

	// only the first stop bit is checked
	always_comb
	begin
		newEntry.data = rxBits[8:0] & dataMask(charBits);
		newEntry.frameError = !bitIn;
		newEntry.overrun = pendingOverrun;
		newEntry.parityError = parityOn &&
			(^newEntry.data ^ parityOdd ^ rxBits[charBits]);
	end

	// fifo, with the shift register as a third level
	assign notEmpty = fifoCount != 2'h0;
	assign room = fifoCount != 2'h2 || pop;
	assign push = (heldValid || frameEnd) && room;
	assign head = fifoMem[rdPtr];

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			heldValid <= 1'b0;
			heldEntry <= '0;
		end
		else if (frameEnd && !room)
		begin
			heldValid <= 1'b1;
			heldEntry <= newEntry;
		end
		else if (heldValid && (room || startSeen))
			heldValid <= 1'b0;
	end

	// overrun rides on the next character stored
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			pendingOverrun <= 1'b0;
		else if (heldValid && !room && startSeen)
			pendingOverrun <= 1'b1;
		else if (frameEnd)
			pendingOverrun <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			fifoCount <= 2'h0;
		end
		else
		begin
			if (push)
				wrPtr <= !wrPtr;
			if (pop)
				rdPtr <= !rdPtr;
			fifoCount <= fifoCount + {1'b0, push} - {1'b0, pop};
		end
	end

	// entries have no reset: a data read of an empty fifo returns a stale or unwritten entry
	always_ff @(posedge sys_clk)
	begin
		if (push)
			fifoMem[wrPtr] <= heldValid ? heldEntry : newEntry;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_master_toggle;
		master && baudTick |=> xckOut != $past(xckOut);
	endproperty
	a_master_toggle: assert property (p_master_toggle)
		else $error("master clock did not toggle");

	property p_async_spacing;
		!syncMode && txBitEn |=> !(txBitEn && !syncMode) [*7];
	endproperty
	a_async_spacing: assert property (p_async_spacing)
		else $error("async bit shorter than eight ticks");

	property p_back_to_back;
		txBitEn && txBusy && txIdx == txLast && txBufFull
			|=> txBusy && !txd && txIdx == 4'h0;
	endproperty
	a_back_to_back: assert property (p_back_to_back)
		else $error("gap between buffered frames");

	property p_stop_high;
		txBusy && txIdx == txLast |-> txd;
	endproperty
	a_stop_high: assert property (p_stop_high)
		else $error("last frame bit not a stop");

	property p_false_start;
		rxState == RX_START && rxSample && filt |=> rxState == RX_IDLE;
	endproperty
	a_false_start: assert property (p_false_start)
		else $error("false start not rejected");

	property p_overrun;
		heldValid && !room && startSeen |=> pendingOverrun && !heldValid;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not recorded");

	property p_pop_one;
		pop && !push |=> fifoCount == $past(fifoCount) - 2'h1;
	endproperty
	a_pop_one: assert property (p_pop_one)
		else $error("read did not pop one entry");

	property p_phase_wrap;
		rxState != RX_IDLE && baudTick && rxPhase == lastPhase
			|=> rxPhase == 4'h0;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap)
		else $error("receiver phase did not wrap");

	c_back_to_back: cover property (p_back_to_back);
	c_overrun: cover property (heldValid && !room && startSeen);
	c_false_start: cover property (rxState == RX_START && rxSample && filt);

endmodule : usart_core

// [test/serial_peer.sv]
/*
 serial_peer: remote asynchronous node, 8N1, one bit = bitCycles clocks.
 assumes: driven from the bench clock; the line idles high between frames.
*/
module serial_peer
(
	// clock
	input  wire logic  sys_clk,
	// serial lines
	input  wire logic  lineIn,
	output logic       lineOut,
	// decoded byte
	output logic [7:0] gotByte,
	output logic       gotValid
);
	timeunit 1ns;
	timeprecision 1ns;
	int bitCycles = 32;
	initial
	begin
		lineOut = 1'b1;
		gotByte = 8'h00;
		gotValid = 1'b0;
	end
	// start low, data lsb first, stop high, then idle high
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			lineOut <= f[i];
			repeat (bitCycles) @(posedge sys_clk);
		end
	endtask : send_byte
	// mid-bit sampling; a start that is high again at mid-bit is dropped
	always
	begin
		@(negedge lineIn);
		repeat (bitCycles / 2) @(posedge sys_clk);
		if (lineIn === 1'b0)
		begin
			for (int i = 0; i < 8; i++)
			begin
				repeat (bitCycles) @(posedge sys_clk);
				gotByte[i] <= lineIn;
			end
			repeat (bitCycles) @(posedge sys_clk);
			gotValid <= 1'b1;
			@(posedge sys_clk);
			gotValid <= 1'b0;
		end
	end
endmodule : serial_peer

// [test/testbench.sv]
/*
 testbench: apb driver, serial peer and result queues for usart_core.
 assumes: serial_peer compiled before; 10 MHz clock.
*/
module testbench
	import usart_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, txd, rxd, xckOut, xckOe, prev;
	logic [7:0]  gotByte, b, rxList[3];
	logic        gotValid;
	logic        xckIn = 1'b0;
	logic        rxDoneIrq, txDoneIrq, txEmptyIrq;
	logic [63:0] readQ[$];
	logic [7:0]  txQ[$];
	int          n_errors = 0;
	int          total_checks = 0;
	int          n;

	usart_core uut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
		.txd(txd), .xckIn(xckIn), .xckOut(xckOut), .xckOe(xckOe),
		.rxDoneIrq(rxDoneIrq), .txDoneIrq(txDoneIrq),
		.txEmptyIrq(txEmptyIrq));
	serial_peer peer (.sys_clk(sys_clk), .lineIn(txd), .lineOut(rxd),
		.gotByte(gotByte), .gotValid(gotValid));

	always #50 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [31:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// the note holds mask and expected value; the monitor compares
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		readQ.push_back({m, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	// read data is taken at the edge that completes the access
	always @(posedge sys_clk)
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			logic [63:0] note;
			note = readQ.pop_front();
			check("prdata", note[31:0], prdata & note[63:32]);
			check("pslverr", {31'h0, paddr > ADDR_PIN_DIR}, {31'h0, pslverr});
		end

	always @(posedge sys_clk)
		if (gotValid)
		begin
			logic [7:0] e;
			e = txQ.pop_front();
			check("txd byte", {24'h0, e}, {24'h0, gotByte});
		end

	// a hang would stall the queues; 40000 cycles covers every frame
	initial
	begin
		#4000000;
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		void'($urandom(32'hab2f));
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(ADDR_CTRL_C, 32'hFF, 32'h06);
		rd(ADDR_BAUD_LO, 32'hFF, 32'h00);
		rd(8'h1C, 32'hFFFFFFFF, 32'h0);
		apb(1'b1, ADDR_BAUD_HI, 32'h0);
		apb(1'b1, ADDR_BAUD_LO, 32'h1);
		rd(ADDR_BAUD_LO, 32'hFF, 32'h01);
		apb(1'b1, ADDR_CTRL_B, 32'hF8);
		// second round in double speed halves the bit time
		for (int r = 0; r < 2; r++)
		begin
			if (r == 1)
				apb(1'b1, ADDR_CTRL_A, 32'h02);
			peer.bitCycles = (r == 1) ? 16 : 32;
			for (int k = 0; k < 2; k++)
			begin
				b = 8'($urandom);
				txQ.push_back(b);
				// a write into a full buffer is dropped, so wait for room
				@(negedge sys_clk);
				while (!txEmptyIrq) @(negedge sys_clk);
				apb(1'b1, ADDR_DATA, {24'h0, b});
			end
			wait (txQ.size() == 0);
		end
		apb(1'b1, ADDR_CTRL_A, 32'h0);
		peer.bitCycles = 32;
		// three frames unread: two in the fifo, one held in the shifter
		for (int k = 0; k < 3; k++)
		begin
			rxList[k] = 8'($urandom);
			peer.send_byte(rxList[k]);
		end
		repeat (40) @(posedge sys_clk);
		@(negedge sys_clk);
		check("rxDoneIrq", 32'h1, {31'h0, rxDoneIrq});
		check("txDoneIrq", 32'h1, {31'h0, txDoneIrq});
		check("txEmptyIrq", 32'h1, {31'h0, txEmptyIrq});
		apb(1'b1, ADDR_CTRL_A, 32'h40);
		@(negedge sys_clk);
		check("txDoneIrq clear", 32'h0, {31'h0, txDoneIrq});
		for (int k = 0; k < 3; k++)
		begin
			rd(ADDR_CTRL_A, 32'h9C, 32'h80);
			rd(ADDR_DATA, 32'hFF, {24'h0, rxList[k]});
		end
		rd(ADDR_CTRL_A, 32'h80, 32'h0);
		@(negedge sys_clk);
		check("rxDoneIrq empty", 32'h0, {31'h0, rxDoneIrq});
		apb(1'b1, ADDR_PIN_DIR, 32'h1);
		apb(1'b1, ADDR_CTRL_C, 32'h46);
		@(negedge sys_clk);
		check("xckOe master", 32'h1, {31'h0, xckOe});
		n = 0;
		prev = xckOut;
		repeat (40)
		begin
			@(negedge sys_clk);
			if (xckOut !== prev)
				n++;
			prev = xckOut;
		end
		check("xck toggles", 32'h1, {31'h0, n >= 19 && n <= 21});
		apb(1'b1, ADDR_PIN_DIR, 32'h0);
		@(negedge sys_clk);
		check("xckOe slave", 32'h0, {31'h0, xckOe});
		// slave: all-ones byte, one bit per external period of eight cycles
		apb(1'b1, ADDR_DATA, 32'hFF);
		n = 0;
		for (int c = 0; c < 96; c++)
		begin
			@(posedge sys_clk);
			if (c % 4 == 0)
				xckIn <= !xckIn;
			@(negedge sys_clk);
			if (txd === 1'b0)
				n++;
		end
		check("slave start bit", 32'h8, n);
		apb(1'b1, ADDR_PIN_DIR, 32'h1);
		apb(1'b1, ADDR_CTRL_C, 32'h06);
		@(negedge sys_clk);
		check("xckOe async", 32'h0, {31'h0, xckOe});
		report_and_stop();
	end
endmodule : testbench
